// *** src/lsbec_pkg.sv ***
/*
 * Constants for the load/store block event counter: event selection codes,
 * unit masks, counter width and reset values.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lsbec_pkg;
   localparam int unsigned EVSEL_W = 8;
   localparam int unsigned CNT_W   = 48;

   localparam logic [7:0] EV_LOAD_BLOCK  = 8'h03;
   localparam logic [7:0] EV_STORE_BLOCK = 8'h04;

   localparam logic [7:0] UM_OVERLAP     = 8'h08;
   localparam logic [7:0] UM_RETIRE      = 8'h10;
   localparam logic [7:0] UM_L1D         = 8'h20;
   localparam logic [7:0] UM_SB_DRAIN    = 8'h01;
   localparam logic [7:0] UM_ORDER       = 8'h02;
   localparam logic [7:0] UM_SNOOP       = 8'h08;

   localparam logic [47:0] CNT_RST       = 48'h0;
   localparam int unsigned SNOOP_RESUB_CYCLES = 1;

   typedef enum logic [6:0] {
      LSBEC_SEL_NONE    = 7'h01,
      LSBEC_SEL_OVERLAP = 7'h02,
      LSBEC_SEL_RETIRE  = 7'h04,
      LSBEC_SEL_L1D     = 7'h08,
      LSBEC_SEL_DRAIN   = 7'h10,
      LSBEC_SEL_ORDER   = 7'h20,
      LSBEC_SEL_SNOOP   = 7'h40
   } lsbec_sel_t;
endpackage

// *** src/lsbec_cond.sv ***
/*
 * Per-condition combiner: ORs a vector of trigger inputs into one hit.
 * Assumes triggers come from logic on the same clock.
 */
`timescale 1ns/1ps
module lsbec_cond #(
   parameter int unsigned N = 4
) (
   // Triggers.
   input  wire logic [N-1:0] i_trig,
   // Combined hit.
   output logic              o_hit
);
   assign o_hit = |i_trig;
endmodule

// *** src/lsbec_top.sv ***
/*
 * Load/store block event counter: decodes an event number and unit mask and
 * advances a general-purpose counter from pipeline condition pulses.
 * Assumes all condition inputs are synchronous to i_clk.
 */
// What this block does
// - 03H/10H counts loads held until retirement.
// - Retirement hold covers uncacheable, split, other loads.
// - 03H/20H counts loads stalled by L1D.
// - Of the misses, only a demand miss counts, and only while the miss tracker is full.
// - 04H/01H counts every store buffer drain cycle.
// - 04H/02H counts store ordering wait cycles.
// - Ordering stall ends at snoop response.
// - 04H/08H counts snoop-taken store port cycles.
// - Snoop-stalled store resubmits next cycle.
// - Overlap fires on misaligned or eight-byte split.
// - Overlap fires on four-kilobyte aliasing.
// - Overlapped load held until store commits.
// - 03H/08H selects the store-overlap load event.
`timescale 1ns/1ps
module lsbec_top
   import lsbec_pkg::*;
#(
   parameter int unsigned CW = lsbec_pkg::CNT_W
) (
   // Clock and reset.
   input  wire logic                         i_clk,
   input  wire logic                         i_nrst,
   // Event selection.
   input  wire logic [lsbec_pkg::EVSEL_W-1:0] i_event_num,
   input  wire logic [lsbec_pkg::EVSEL_W-1:0] i_unit_mask,
   input  wire logic                         i_count_en,
   // Store-overlap load block triggers.
   input  wire logic                         i_ovl_partial,
   input  wire logic                         i_ovl_misaligned_store,
   input  wire logic                         i_ovl_eight_byte_split,
   input  wire logic                         i_ovl_page_alias,
   input  wire logic                         i_ovl_store_committed,
   // Retirement hold triggers, one pulse per blocked load.
   input  wire logic                         i_ret_uncacheable,
   input  wire logic                         i_ret_line_split,
   input  wire logic                         i_ret_other,
   // First-level cache stall triggers.
   input  wire logic                         i_l1d_miss_demand,
   input  wire logic                         i_l1d_miss_sw_pf,
   input  wire logic                         i_l1d_miss_hw_pf,
   input  wire logic                         i_l1d_miss_done,
   input  wire logic                         i_l1d_line_split,
   input  wire logic                         i_l1d_partial_read,
   input  wire logic                         i_l1d_locked_load,
   // Store side conditions.
   input  wire logic                         i_store_buffer_empty_out,
   input  wire logic                         i_order_wait_start,
   input  wire logic                         i_order_snoop_resp,
   input  wire logic                         i_snoop_port_busy,
   input  wire logic                         i_store_snoop_stall,
   // Counter.
   output logic [CW-1:0]                     o_count,
   output logic                              o_sel_valid,
   output logic                              o_load_overlap_held,
   output logic                              o_store_resubmit
);
   import lsbec_pkg::*;

   localparam int unsigned MW = 4;

   typedef struct packed {
      logic [CW-1:0] cnt;
      lsbec_sel_t    sel;
      logic          ovl_held;
      logic          order_wait;
      logic [MW-1:0] miss_out;
      logic          resub;
   } lsbec_state_t;

   lsbec_state_t s_q;
   lsbec_state_t s_d;

   logic ovl_trig;
   logic ret_hit;
   logic l1d_other;
   logic miss_full;
   logic ev_inc;
   logic snoop_cyc;
   logic [2:0] miss_new;
   logic [MW-1:0] miss_sum;

   lsbec_cond #(.N(4)) u_ovl (
      .i_trig ({i_ovl_partial, i_ovl_misaligned_store, i_ovl_eight_byte_split, i_ovl_page_alias}),
      .o_hit  (ovl_trig)
   );

   lsbec_cond #(.N(3)) u_ret (
      .i_trig ({i_ret_uncacheable, i_ret_line_split, i_ret_other}),
      .o_hit  (ret_hit)
   );

   lsbec_cond #(.N(3)) u_l1d (
      .i_trig ({i_l1d_line_split, i_l1d_partial_read, i_l1d_locked_load}),
      .o_hit  (l1d_other)
   );

   assign miss_new = {2'b00, i_l1d_miss_demand} + {2'b00, i_l1d_miss_sw_pf} + {2'b00, i_l1d_miss_hw_pf};
   assign miss_full = (s_q.miss_out == {MW{1'b1}});
   assign snoop_cyc = i_snoop_port_busy && i_store_snoop_stall;

   always_comb begin
      s_d = s_q;
      s_d.sel = LSBEC_SEL_NONE;
      if (i_event_num == EV_LOAD_BLOCK) begin
         case (i_unit_mask)
            UM_OVERLAP: s_d.sel = LSBEC_SEL_OVERLAP;
            UM_RETIRE:  s_d.sel = LSBEC_SEL_RETIRE;
            UM_L1D:     s_d.sel = LSBEC_SEL_L1D;
            default:    s_d.sel = LSBEC_SEL_NONE;
         endcase
      end else if (i_event_num == EV_STORE_BLOCK) begin
         case (i_unit_mask)
            UM_SB_DRAIN: s_d.sel = LSBEC_SEL_DRAIN;
            UM_ORDER:    s_d.sel = LSBEC_SEL_ORDER;
            UM_SNOOP:    s_d.sel = LSBEC_SEL_SNOOP;
            default:     s_d.sel = LSBEC_SEL_NONE;
         endcase
      end
      if (ovl_trig) begin
         s_d.ovl_held = 1'b1;
      end else if (i_ovl_store_committed) begin
         s_d.ovl_held = 1'b0;
      end
      // ordering wait ends on snoop response.
      if (i_order_snoop_resp) begin
         s_d.order_wait = 1'b0;
      end else if (i_order_wait_start) begin
         s_d.order_wait = 1'b1;
      end
      miss_sum = s_q.miss_out + {1'b0, miss_new};
      if (i_l1d_miss_done && (miss_sum != {MW{1'b0}})) begin
         miss_sum = miss_sum - {{(MW-1){1'b0}}, 1'b1};
      end
      if (miss_sum < s_q.miss_out && miss_new != 3'b000) begin
         miss_sum = {MW{1'b1}};
      end
      s_d.miss_out = miss_sum;
      s_d.resub = snoop_cyc;
      ev_inc = 1'b0;
      case (s_q.sel)
         LSBEC_SEL_OVERLAP: ev_inc = ovl_trig;
         LSBEC_SEL_RETIRE:  ev_inc = ret_hit;
         LSBEC_SEL_L1D:     ev_inc = l1d_other || (miss_full && i_l1d_miss_demand);
         LSBEC_SEL_DRAIN:   ev_inc = i_store_buffer_empty_out;
         LSBEC_SEL_ORDER:   ev_inc = s_q.order_wait && !i_order_snoop_resp;
         LSBEC_SEL_SNOOP:   ev_inc = snoop_cyc;
         default:           ev_inc = 1'b0;
      endcase
      if (ev_inc && i_count_en) begin
         s_d.cnt = s_q.cnt + {{(CW-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s_q.cnt        <= CNT_RST[CW-1:0];
         s_q.sel        <= LSBEC_SEL_NONE;
         s_q.ovl_held   <= 1'b0;
         s_q.order_wait <= 1'b0;
         s_q.miss_out   <= {MW{1'b0}};
         s_q.resub      <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_count             = s_q.cnt;
   assign o_sel_valid         = (s_q.sel != LSBEC_SEL_NONE);
   assign o_load_overlap_held = s_q.ovl_held;
   assign o_store_resubmit    = s_q.resub;

   property p_hold_invalid;
      @(posedge i_clk) disable iff (!i_nrst)
         (s_q.sel == LSBEC_SEL_NONE) |=> (o_count == $past(o_count));
   endproperty
   a_hold_invalid: assert property (p_hold_invalid) else $error("count moved on invalid selection");

   property p_drain;
      @(posedge i_clk) disable iff (!i_nrst)
         (s_q.sel == LSBEC_SEL_DRAIN && i_count_en && i_store_buffer_empty_out) |=> (o_count == $past(o_count) + 1'b1);
   endproperty
   a_drain: assert property (p_drain) else $error("drain cycle not counted");

   property p_retire;
      @(posedge i_clk) disable iff (!i_nrst)
         (s_q.sel == LSBEC_SEL_RETIRE && i_count_en && i_ret_uncacheable) |=> (o_count != $past(o_count));
   endproperty
   a_retire: assert property (p_retire) else $error("retirement block not counted");

   property p_order_end;
      @(posedge i_clk) disable iff (!i_nrst)
         i_order_snoop_resp |=> !s_q.order_wait;
   endproperty
   a_order_end: assert property (p_order_end) else $error("order wait outlived snoop response");

   property p_order_cnt;
      @(posedge i_clk) disable iff (!i_nrst)
         (s_q.sel == LSBEC_SEL_ORDER && s_q.order_wait && !i_order_snoop_resp && i_count_en)
            |=> (o_count == $past(o_count) + 1'b1);
   endproperty
   a_order_cnt: assert property (p_order_cnt) else $error("order wait cycle not counted");

   property p_snoop;
      @(posedge i_clk) disable iff (!i_nrst)
         (s_q.sel == LSBEC_SEL_SNOOP && snoop_cyc && i_count_en) |=> (o_count == $past(o_count) + 1'b1);
   endproperty
   a_snoop: assert property (p_snoop) else $error("snoop stall not counted");

   property p_resub;
      @(posedge i_clk) disable iff (!i_nrst)
         snoop_cyc |=> o_store_resubmit;
   endproperty
   a_resub: assert property (p_resub) else $error("store not resubmitted");

   property p_ovl_hold;
      @(posedge i_clk) disable iff (!i_nrst)
         (o_load_overlap_held && !i_ovl_store_committed) |=> o_load_overlap_held;
   endproperty
   a_ovl_hold: assert property (p_ovl_hold) else $error("overlap hold released early");

   property p_alias;
      @(posedge i_clk) disable iff (!i_nrst)
         i_ovl_page_alias |=> o_load_overlap_held;
   endproperty
   a_alias: assert property (p_alias) else $error("page alias did not block load");

   property p_split_block;
      @(posedge i_clk) disable iff (!i_nrst)
         (i_ovl_misaligned_store || i_ovl_eight_byte_split) |=> o_load_overlap_held;
   endproperty
   a_split_block: assert property (p_split_block) else $error("misaligned or split load not blocked");

   property p_overlap_cnt;
      @(posedge i_clk) disable iff (!i_nrst)
         (s_q.sel == LSBEC_SEL_OVERLAP && ovl_trig && i_count_en) |=> (o_count == $past(o_count) + 1'b1);
   endproperty
   a_overlap_cnt: assert property (p_overlap_cnt) else $error("overlap load not counted");

   property p_sel_overlap;
      @(posedge i_clk) disable iff (!i_nrst)
         (i_event_num == EV_LOAD_BLOCK && i_unit_mask == UM_OVERLAP) |=> o_sel_valid;
   endproperty
   a_sel_overlap: assert property (p_sel_overlap) else $error("overlap selection not accepted");

   property p_ret_split;
      @(posedge i_clk) disable iff (!i_nrst)
         (s_q.sel == LSBEC_SEL_RETIRE && i_count_en && (i_ret_line_split || i_ret_other))
            |=> (o_count == $past(o_count) + 1'b1);
   endproperty
   a_ret_split: assert property (p_ret_split) else $error("held load not counted");

   property p_l1d_cnt;
      @(posedge i_clk) disable iff (!i_nrst)
         (s_q.sel == LSBEC_SEL_L1D && l1d_other && i_count_en) |=> (o_count == $past(o_count) + 1'b1);
   endproperty
   a_l1d_cnt: assert property (p_l1d_cnt) else $error("cache stall not counted");

   property p_miss_full_cnt;
      @(posedge i_clk) disable iff (!i_nrst)
         (s_q.sel == LSBEC_SEL_L1D && miss_full && i_l1d_miss_demand && i_count_en)
            |=> (o_count == $past(o_count) + 1'b1);
   endproperty
   a_miss_full_cnt: assert property (p_miss_full_cnt) else $error("miss limit stall not counted");

   property p_en_hold;
      @(posedge i_clk) disable iff (!i_nrst)
         !i_count_en |=> (o_count == $past(o_count));
   endproperty
   a_en_hold: assert property (p_en_hold) else $error("count moved while disabled");
endmodule

// *** tb/lsbec_pipe_model.sv ***
/*
 * Load/store pipeline model: drives the condition lines of the event counter.
 * Assumes the bench changes the pattern just after each rising edge.
 */
`timescale 1ns/1ps
module lsbec_pipe_model (
   // Clock and reset.
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // Pattern request.
   input  wire logic [19:0] i_pat,
   // Condition lines.
   output logic      [19:0] o_cond
);
   // one pulse per load or stall.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cond <= 20'h0;
      end else begin
         o_cond <= i_pat;
      end
   end
endmodule

// *** tb/tb_lsbec_top.sv ***
/*
 * Self-checking bench for the load/store block event counter.
 * Assumes the pipeline model and the design package are compiled first.
 */
`timescale 1ns/1ps
module tb_lsbec_top;
   import lsbec_pkg::*;
   logic        clk, nrst, en, sv, held, resub;
   logic [7:0]  num, msk;
   logic [19:0] pat, c;
   logic [47:0] cnt, base;
   int          error_cnt, num_checks;

   lsbec_pipe_model u_lsbec_pipe_model (.i_clk(clk), .i_nrst(nrst), .i_pat(pat), .o_cond(c));
   lsbec_top u_lsbec_top (
      .i_clk(clk), .i_nrst(nrst), .i_event_num(num), .i_unit_mask(msk), .i_count_en(en),
      .i_ovl_partial(c[0]), .i_ovl_misaligned_store(c[1]), .i_ovl_eight_byte_split(c[2]),
      .i_ovl_page_alias(c[3]), .i_ovl_store_committed(c[4]), .i_ret_uncacheable(c[5]),
      .i_ret_line_split(c[6]), .i_ret_other(c[7]), .i_l1d_miss_demand(c[8]), .i_l1d_miss_sw_pf(c[9]),
      .i_l1d_miss_hw_pf(c[10]), .i_l1d_miss_done(c[11]), .i_l1d_line_split(c[12]),
      .i_l1d_partial_read(c[13]), .i_l1d_locked_load(c[14]), .i_store_buffer_empty_out(c[15]),
      .i_order_wait_start(c[16]), .i_order_snoop_resp(c[17]), .i_snoop_port_busy(c[18]),
      .i_store_snoop_stall(c[19]), .o_count(cnt), .o_sel_valid(sv), .o_load_overlap_held(held),
      .o_store_resubmit(resub));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic wrap_up();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic sel(input logic [7:0] e, input logic [7:0] m);
      num = e;
      msk = m;
      tick(3);
      base = cnt;
   endtask

   task automatic pulse(input logic [19:0] p);
      pat = p;
      tick(1);
      pat = 20'h0;
      tick(1);
   endtask

   // Holds a pattern for n cycles and checks the increase and the valid flag.
   task automatic ev(input logic [7:0] e, input logic [7:0] m, input logic [19:0] p, input int n,
                     input int x, input logic v);
      sel(e, m);
      pat = p;
      tick(n);
      pat = 20'h0;
      tick(4);
      chk(cnt, base + 48'(x));
      chk(48'(sv), 48'(v));
   endtask

   task automatic t_order();
      sel(8'h04, 8'h02);
      pulse(20'h10000);
      tick(3);
      pulse(20'h20000);
      tick(3);
      chk(cnt, base + 48'h4);
      pulse(20'h30000);
      tick(4);
      chk(cnt, base + 48'h4);
   endtask

   task automatic t_snoop();
      sel(8'h04, 8'h08);
      pat = 20'hc0000;
      tick(1);
      pat = 20'h0;
      tick(1);
      chk(48'(resub), 48'h1);
      tick(1);
      chk(48'(resub), 48'h0);
      tick(2);
      chk(cnt, base + 48'h1);
   endtask

   task automatic t_hold();
      sel(8'h03, 8'h08);
      pulse(20'h00001);
      tick(4);
      chk(48'(held), 48'h1);
      pulse(20'h00010);
      chk(48'(held), 48'h0);
      pulse(20'h00012);
      chk(48'(held), 48'h1);
      pulse(20'h00010);
      chk(48'(held), 48'h0);
   endtask

   task automatic t_miss();
      sel(8'h03, 8'h20);
      for (int i = 0; i < 15; i++) begin
         pulse(20'h00100 << (i / 5));
      end
      chk(cnt, base);
      pulse(20'h00100);
      tick(2);
      chk(cnt, base + 48'h1);
      pulse(20'h00800);
      pulse(20'h00100);
      chk(cnt, base + 48'h1);
      pulse(20'h00100);
      chk(cnt, base + 48'h2);
   endtask

   initial begin
      nrst = 1'b0;
      en = 1'b1;
      num = 8'h0;
      msk = 8'h0;
      pat = 20'h0;
      error_cnt = 0;
      num_checks = 0;
      repeat (5) @(posedge clk);
      #1 nrst = 1'b1;
      chk(cnt, 48'h0);
      ev(8'h03, 8'h10, 20'h00020, 1, 1, 1'b1);
      ev(8'h03, 8'h10, 20'h00040, 2, 2, 1'b1);
      ev(8'h03, 8'h10, 20'h000e0, 1, 1, 1'b1);
      ev(8'h03, 8'h08, 20'h00001, 1, 1, 1'b1);
      ev(8'h03, 8'h08, 20'h00002, 2, 2, 1'b1);
      ev(8'h03, 8'h08, 20'h00004, 1, 1, 1'b1);
      ev(8'h03, 8'h08, 20'h00008, 1, 1, 1'b1);
      ev(8'h03, 8'h20, 20'h07000, 3, 3, 1'b1);
      ev(8'h04, 8'h01, 20'h08000, 5, 5, 1'b1);
      ev(8'h04, 8'h01, 20'h00020, 1, 0, 1'b1);
      ev(8'h03, 8'h40, 20'h00020, 1, 0, 1'b0);
      ev(8'h05, 8'h01, 20'h08000, 3, 0, 1'b0);
      en = 1'b0;
      ev(8'h04, 8'h01, 20'h08000, 3, 0, 1'b1);
      en = 1'b1;
      t_order();
      t_snoop();
      t_hold();
      t_miss();
      nrst = 1'b0;
      tick(1);
      chk(cnt, 48'h0);
      nrst = 1'b1;
      tick(2);
      wrap_up();
   end

   initial begin
      #200000;
      error_cnt++;
      wrap_up();
   end
endmodule
